// >>> lvpi_pkg.sv
// Purpose: Shared constants for the low-voltage and periodic interrupt block
// Assumes: Classic Wishbone, 32-bit data, byte registers in the low lane
// Notes:   Register indices are word indices; byte address is four times the index
package lvpi_pkg;
    // Register indices and byte addresses
    localparam logic [7:0] LVPI_IDX_LV_CTL   = 8'h11;
    localparam logic [7:0] LVPI_IDX_PI_CTL   = 8'h12;
    localparam logic [7:0] LVPI_IDX_IRQ_STAT = 8'h13;
    localparam logic [7:0] LVPI_IDX_IRQ_EN   = 8'h14;
    localparam logic [7:0] LVPI_IDX_IRQ_CLR  = 8'h15;
    localparam logic [7:0] LVPI_IDX_RATE     = 8'h16;
    localparam logic [9:0] LVPI_ADR_LV_CTL   = {LVPI_IDX_LV_CTL, 2'b00};
    localparam logic [9:0] LVPI_ADR_PI_CTL   = {LVPI_IDX_PI_CTL, 2'b00};
    localparam logic [9:0] LVPI_ADR_IRQ_STAT = {LVPI_IDX_IRQ_STAT, 2'b00};
    localparam logic [9:0] LVPI_ADR_IRQ_EN   = {LVPI_IDX_IRQ_EN, 2'b00};
    localparam logic [9:0] LVPI_ADR_IRQ_CLR  = {LVPI_IDX_IRQ_CLR, 2'b00};
    localparam logic [9:0] LVPI_ADR_RATE     = {LVPI_IDX_RATE, 2'b00};
    // Low-voltage control fields
    localparam int LVPI_LV_STATUS_BIT = 2;
    localparam int LVPI_LV_IRQEN_BIT  = 1;
    localparam int LVPI_LV_FLAG_BIT   = 0;
    // Periodic control fields
    localparam int LVPI_PI_CLKSEL_BIT = 7;
    localparam int LVPI_PI_WAVE_BIT   = 4;
    localparam int LVPI_PI_EXTEN_BIT  = 3;
    localparam int LVPI_PI_FEAT_BIT   = 2;
    localparam int LVPI_PI_IRQEN_BIT  = 1;
    localparam int LVPI_PI_FLAG_BIT   = 0;
    // Interrupt status layout
    localparam int LVPI_EV_LV = 0;
    localparam int LVPI_EV_PI = 1;
    localparam int LVPI_NEV   = 2;
    // Reset values
    localparam logic [7:0]  LVPI_RST_BYTE = 8'h00;
    localparam logic [15:0] LVPI_RST_RATE = 16'h0000;
    // Autonomous clock: bus clock divided by this count
    localparam logic [7:0]  LVPI_ACLK_DIV = 8'h64;
    // Minimum period in selected ticks for rate 0, and its half for the pulse
    localparam logic [16:0] LVPI_MIN_TICKS  = 17'h00002;
    localparam logic [16:0] LVPI_PULSE_TICKS = LVPI_MIN_TICKS >> 1;
endpackage

// >>> lvpi_sync.sv
// Purpose: Three-stage synchroniser for one level from outside the domain
// Assumes: Single clock i_mclk, asynchronous active-low reset
// Notes:   A change is accepted once stages two and three agree
`timescale 1ns/1ps
module lvpi_sync
    import lvpi_pkg::*;
(
    input  wire logic i_mclk,
    input  wire logic i_nrst,
    input  wire logic i_async,
    output logic      o_level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic lvl_r;
    logic agree;

    // Stage two and three agreement decides the level
    assign agree   = (s2_r == s3_r);
    assign o_level = lvl_r;

    // Shift chain and accepted level
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            s1_r  <= 1'b0;
            s2_r  <= 1'b0;
            s3_r  <= 1'b0;
            lvl_r <= 1'b0;
        end
        else
        begin
            s1_r <= i_async;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (agree)
                lvl_r <= s3_r;
        end
    end
endmodule

// >>> lvpi_timer.sv
// Purpose: Periodic timer with pulse and square-wave outputs
// Assumes: i_tick is a one-cycle enable from the selected source
// Notes:   Period is rate plus the minimum period, in ticks
`timescale 1ns/1ps
module lvpi_timer
    import lvpi_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_nrst,
    input  wire logic        i_run,
    input  wire logic        i_tick,
    input  wire logic [15:0] i_rate,
    output logic             o_expire,
    output logic             o_pulse,
    output logic             o_square
);
    logic [16:0] cnt_r;
    logic [16:0] plen_r;
    logic        sq_r;
    logic        ex_r;
    logic [16:0] last;
    logic        hit;

    // Terminal count from the rate value
    assign last     = {1'b0, i_rate} + LVPI_MIN_TICKS - 17'h00001;
    assign hit      = i_run && i_tick && (cnt_r >= last);
    assign o_expire = ex_r;
    assign o_pulse  = (plen_r != 17'h00000);
    assign o_square = sq_r;

    // Count ticks, restart on expiry, shape waveforms
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            cnt_r  <= 17'h00000;
            plen_r <= 17'h00000;
            sq_r   <= 1'b0;
            ex_r   <= 1'b0;
        end
        else if (!i_run)
        begin
            cnt_r  <= 17'h00000;
            plen_r <= 17'h00000;
            sq_r   <= 1'b0;
            ex_r   <= 1'b0;
        end
        else
        begin
            ex_r <= hit;
            if (hit)
            begin
                cnt_r  <= 17'h00000;
                plen_r <= LVPI_PULSE_TICKS;
                sq_r   <= ~sq_r;
            end
            else
            begin
                if (i_tick)
                    cnt_r <= cnt_r + 17'h00001;
                if (i_tick && plen_r != 17'h00000)
                    plen_r <= plen_r - 17'h00001;
            end
        end
    end
endmodule

// >>> lvpi_top.sv
// Purpose: Low-voltage flag and autonomous periodic interrupt timer
// Assumes: Classic Wishbone slave, 32-bit data, register byte in lane 0
// Notes:   Ack comes one cycle after the request, lasts one cycle
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
// What this block does
// - Read-only low-voltage status at bit 2 follows the supply; writes ignored.
// - Low-voltage flag sets on any status change; cleared by writing one.
// - Low-voltage interrupt requested while its enable and flag are both set.
// - Enable and flag writable anytime; upper five bits read zero.
// - Clock select bit 7: 0 autonomous, 1 bus; changeable only while disabled.
// - Feature enable bit 2 starts the periodic timer; clearing stops it.
// - Waveform reaches output pin only with external access and feature enabled.
// - Select 0: high pulse each period end, half the minimum period wide.
// - Select 1: square clock of twice the timer period.
// - Periodic flag sets each elapsed period; cleared by writing one.
// - Periodic interrupt requested while its enable and flag are both set.
module lvpi_top
    import lvpi_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_nrst,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [9:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic [31:0]      o_wb_dat,
    output logic             o_wb_ack,
    input  wire logic        i_low_voltage,
    output logic             o_lv_irq,
    output logic             o_pi_irq,
    output logic             o_irq,
    output logic             o_periodic_output_pin
);
    logic        ack_r;
    logic [31:0] rdat_r;
    logic        lv_irqen_r;
    logic        lv_flag_r;
    logic        lv_prev_r;
    logic        clksel_r;
    logic        wave_r;
    logic        exten_r;
    logic        feat_r;
    logic        pi_irqen_r;
    logic        pi_flag_r;
    logic [15:0] rate_r;
    logic [LVPI_NEV-1:0] stat_r;
    logic [LVPI_NEV-1:0] en_r;
    logic [7:0]  div_r;
    logic        aclk_tick_r;
    logic        pin_r;

    logic        lv_level;
    logic        lv_change;
    logic        req;
    logic        wr;
    logic        wr0;
    logic        wr1;
    logic        hit_lv;
    logic        hit_pi;
    logic        hit_stat;
    logic        hit_en;
    logic        hit_clr;
    logic        hit_rate;
    logic [7:0]  wbyte;
    logic [7:0]  lv_byte;
    logic [7:0]  pi_byte;
    logic [31:0] rmux;
    logic        tick;
    logic        expire;
    logic        pulse;
    logic        square;
    logic [LVPI_NEV-1:0] ev;
    logic [LVPI_NEV-1:0] clr;

    // Supply level crossing into the clock domain
    lvpi_sync u_sync (
        .i_mclk  (i_mclk),
        .i_nrst  (i_nrst),
        .i_async (i_low_voltage),
        .o_level (lv_level)
    );

    // Selected tick source feeds the timer
    assign tick = clksel_r ? 1'b1 : aclk_tick_r;

    lvpi_timer u_timer (
        .i_mclk   (i_mclk),
        .i_nrst   (i_nrst),
        .i_run    (feat_r),
        .i_tick   (tick),
        .i_rate   (rate_r),
        .o_expire (expire),
        .o_pulse  (pulse),
        .o_square (square)
    );

    // Bus decode, new request only when no ack pending
    assign req      = i_wb_cyc && i_wb_stb && !ack_r;
    assign wr       = req && i_wb_we;
    assign wr0      = wr && i_wb_sel[0];
    assign wr1      = wr && i_wb_sel[1];
    assign wbyte    = i_wb_dat[7:0];
    assign hit_lv   = (i_wb_adr == LVPI_ADR_LV_CTL);
    assign hit_pi   = (i_wb_adr == LVPI_ADR_PI_CTL);
    assign hit_stat = (i_wb_adr == LVPI_ADR_IRQ_STAT);
    assign hit_en   = (i_wb_adr == LVPI_ADR_IRQ_EN);
    assign hit_clr  = (i_wb_adr == LVPI_ADR_IRQ_CLR);
    assign hit_rate = (i_wb_adr == LVPI_ADR_RATE);

    // Register byte images
    assign lv_byte = {5'b00000, lv_level, lv_irqen_r, lv_flag_r};
    assign pi_byte = {clksel_r, 2'b00, wave_r, exten_r, feat_r, pi_irqen_r, pi_flag_r};

    // Read mux; unmapped and write-only addresses read zero
    assign rmux = hit_lv   ? {24'h000000, lv_byte} :
                  hit_pi   ? {24'h000000, pi_byte} :
                  hit_stat ? {30'h00000000, stat_r} :
                  hit_en   ? {30'h00000000, en_r} :
                  hit_rate ? {16'h0000, rate_r} :
                  32'h00000000;

    // Status change and sticky clear strobes
    assign lv_change = (lv_level != lv_prev_r);
    assign ev        = {expire, lv_change};
    assign clr       = (wr0 && hit_clr) ? wbyte[LVPI_NEV-1:0] : {LVPI_NEV{1'b0}};

    // Interrupt outputs
    assign o_lv_irq = lv_irqen_r && lv_flag_r;
    assign o_pi_irq = pi_irqen_r && pi_flag_r;
    assign o_irq    = |(stat_r & en_r);
    assign o_wb_ack = ack_r;
    assign o_wb_dat = rdat_r;
    assign o_periodic_output_pin = pin_r;

    // Bus answer one cycle after the request
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            ack_r  <= 1'b0;
            rdat_r <= 32'h00000000;
        end
        else
        begin
            ack_r  <= req;
            rdat_r <= req ? rmux : 32'h00000000;
        end
    end

    // Autonomous clock divider, one-cycle tick
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            div_r       <= 8'h00;
            aclk_tick_r <= 1'b0;
        end
        else
        begin
            aclk_tick_r <= (div_r == LVPI_ACLK_DIV - 8'h01);
            div_r       <= (div_r == LVPI_ACLK_DIV - 8'h01) ? 8'h00 : div_r + 8'h01;
        end
    end

    // Low-voltage control register and flag
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            lv_irqen_r <= 1'b0;
            lv_flag_r  <= 1'b0;
            lv_prev_r  <= 1'b0;
        end
        else
        begin
            lv_prev_r <= lv_level;
            if (wr0 && hit_lv)
                lv_irqen_r <= wbyte[LVPI_LV_IRQEN_BIT];
            if (lv_change)
                lv_flag_r <= 1'b1;
            else if (wr0 && hit_lv && wbyte[LVPI_LV_FLAG_BIT])
                lv_flag_r <= 1'b0;
        end
    end

    // Periodic control register and flag
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            clksel_r   <= 1'b0;
            wave_r     <= 1'b0;
            exten_r    <= 1'b0;
            feat_r     <= 1'b0;
            pi_irqen_r <= 1'b0;
            pi_flag_r  <= 1'b0;
        end
        else
        begin
            if (wr0 && hit_pi)
            begin
                if (!feat_r && !wbyte[LVPI_PI_FEAT_BIT])
                    clksel_r <= wbyte[LVPI_PI_CLKSEL_BIT];
                wave_r     <= wbyte[LVPI_PI_WAVE_BIT];
                exten_r    <= wbyte[LVPI_PI_EXTEN_BIT];
                feat_r     <= wbyte[LVPI_PI_FEAT_BIT];
                pi_irqen_r <= wbyte[LVPI_PI_IRQEN_BIT];
            end
            if (expire)
                pi_flag_r <= 1'b1;
            else if (wr0 && hit_pi && wbyte[LVPI_PI_FLAG_BIT])
                pi_flag_r <= 1'b0;
        end
    end

    // Rate value register
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
            rate_r <= LVPI_RST_RATE;
        else
        begin
            if (wr0 && hit_rate)
                rate_r[7:0] <= wbyte;
            if (wr1 && hit_rate)
                rate_r[15:8] <= i_wb_dat[15:8];
        end
    end

    // Shared status and enable, set wins over clear
    genvar g;
    generate
        for (g = 0; g < LVPI_NEV; g++)
        begin : g_ev
            always_ff @(posedge i_mclk or negedge i_nrst)
            begin
                if (!i_nrst)
                begin
                    stat_r[g] <= 1'b0;
                    en_r[g]   <= 1'b0;
                end
                else
                begin
                    if (ev[g])
                        stat_r[g] <= 1'b1;
                    else if (clr[g])
                        stat_r[g] <= 1'b0;
                    if (wr0 && hit_en)
                        en_r[g] <= wbyte[g];
                end
            end
        end
    endgenerate

    // External waveform gating
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
            pin_r <= 1'b0;
        else
            pin_r <= exten_r && feat_r && (wave_r ? square : pulse);
    end
endmodule

// >>> lvpi_asserts.sv
// Purpose: Port-level assertions for lvpi_top
// Assumes: Shadow bits follow acked control writes
// Notes:   Bound to every lvpi_top instance
`timescale 1ns/1ps
module lvpi_asserts
    import lvpi_pkg::*;
(
    input wire logic        i_mclk,
    input wire logic        i_nrst,
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic        i_wb_we,
    input wire logic [9:0]  i_wb_adr,
    input wire logic [3:0]  i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic [31:0] o_wb_dat,
    input wire logic        o_wb_ack,
    input wire logic        i_low_voltage,
    input wire logic        o_lv_irq,
    input wire logic        o_pi_irq,
    input wire logic        o_irq,
    input wire logic        o_periodic_output_pin
);
    logic [7:0] lv_r;
    logic [7:0] pi_r;
    logic [1:0] en_r;
    logic       wr;
    logic       lv_rd;
    // Writes land at the request edge, as in the design
    assign wr    = i_wb_cyc && i_wb_stb && !o_wb_ack && i_wb_we && i_wb_sel[0];
    assign lv_rd = o_wb_ack && !i_wb_we && (i_wb_adr == LVPI_ADR_LV_CTL);
    // Shadow copies of control bits
    always_ff @(posedge i_mclk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            lv_r <= 8'h00;
            pi_r <= 8'h00;
            en_r <= 2'h0;
        end
        else if (wr)
        begin
            if (i_wb_adr == LVPI_ADR_LV_CTL)
                lv_r <= i_wb_dat[7:0];
            if (i_wb_adr == LVPI_ADR_PI_CTL)
                pi_r <= {(pi_r[2] || i_wb_dat[2]) ? pi_r[7] : i_wb_dat[7], i_wb_dat[6:0]};
            if (i_wb_adr == LVPI_ADR_IRQ_EN)
                en_r <= i_wb_dat[1:0];
        end
    end
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_nrst);
    AST_ACK_NEXT: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("ack late");
    AST_ACK_ONE: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack too long");
    AST_DAT_IDLE: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
        else $error("read data without ack");
    AST_LV_READ: assert property (lv_rd |-> o_wb_dat[7:3] == 5'h00 && o_wb_dat[1] == lv_r[1])
        else $error("bad low-voltage control read");
    AST_LV_STATUS: assert property (($stable(i_low_voltage))[*8] ##0 lv_rd |-> o_wb_dat[2] == i_low_voltage)
        else $error("status does not follow supply");
    AST_LV_IRQ: assert property (o_lv_irq |-> lv_r[1])
        else $error("low-voltage request while disabled");
    AST_PI_IRQ: assert property (o_pi_irq |-> pi_r[1])
        else $error("periodic request while disabled");
    AST_IRQ_MASK: assert property (o_irq |-> en_r != 2'h0)
        else $error("interrupt with all enables off");
    AST_PIN_OFF: assert property ((!(pi_r[3] && pi_r[2]))[*2] |-> !o_periodic_output_pin)
        else $error("pin driven while off");
    AST_PULSE: assert property ($rose(o_periodic_output_pin) && pi_r[7] && !pi_r[4] && $stable(pi_r) |=> !o_periodic_output_pin)
        else $error("pulse wider than one tick");
    cover property (o_lv_irq);
    cover property (o_pi_irq);
    cover property (o_irq);
endmodule

bind lvpi_top lvpi_asserts i_chk (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_low_voltage(i_low_voltage),
    .o_lv_irq(o_lv_irq), .o_pi_irq(o_pi_irq), .o_irq(o_irq),
    .o_periodic_output_pin(o_periodic_output_pin)
);

// >>> test_low_voltage_and_periodic_interrupt.sv
// Purpose: Self-checking bench for lvpi_top
// Assumes: Bus clock selected for timer runs
// Notes:   A monitor checks read data off a queue
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
module test_low_voltage_and_periodic_interrupt
    import lvpi_pkg::*;
;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [9:0]  adr = 10'h000;
    logic [31:0] wdat = 32'h0;
    logic        lowv = 1'b0;
    logic [31:0] rdat;
    logic        ack, lv_irq, pi_irq, irq, pin;
    logic [15:0] expq[$];
    logic [9:0]  ra[6] = '{LVPI_ADR_LV_CTL, LVPI_ADR_PI_CTL, LVPI_ADR_IRQ_STAT,
                           LVPI_ADR_IRQ_EN, LVPI_ADR_RATE, 10'h3FC};
    logic [7:0]  d;
    logic [7:0]  r;
    int          n;
    int          bad_count = 0;
    int          total_checks = 0;
    always #5 clk = ~clk;
    lvpi_top i_dut (
        .i_mclk(clk), .i_nrst(nrst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_low_voltage(lowv), .o_lv_irq(lv_irq), .o_pi_irq(pi_irq), .o_irq(irq),
        .o_periodic_output_pin(pin)
    );
    // Monitor: each read answer against the oldest note
    always @(posedge clk)
    begin
        if (ack === 1'b1 && !we && expq.size() > 0)
        begin
            `CHK(rdat[7:0] & expq[0][15:8], expq[0][7:0])
            void'(expq.pop_front());
        end
    end
    task automatic finish_test();
        $display("Checks %0d, errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // One classic cycle, held until ack
    task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] v, input logic [7:0] m = 8'hFF);
        int k;
        k = 0;
        if (!w)
            expq.push_back({m, v & m});
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, v};
        do
        begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        cyc <= 1'b0;
        stb <= 1'b0;
        if (k >= 20)
        begin
            bad_count++;
            finish_test();
        end
        @(posedge clk);
    endtask
    // Cycles until the pin reaches a level
    task automatic wpin(input logic lvl, output int c);
        c = 0;
        while (pin !== lvl && c < 1000)
        begin
            @(posedge clk);
            c++;
        end
        if (c >= 1000)
        begin
            bad_count++;
            finish_test();
        end
    endtask
    // Main sequence
    initial
    begin
        void'($urandom(84));
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        foreach (ra[i]) wb(1'b0, ra[i], 8'h00);
        d = 8'($urandom());
        wb(1'b1, LVPI_ADR_LV_CTL, d | 8'h03);
        wb(1'b0, LVPI_ADR_LV_CTL, 8'h02);
        lowv <= 1'b1;
        repeat (8) @(posedge clk);
        wb(1'b0, LVPI_ADR_LV_CTL, 8'h07);
        `CHK(lv_irq, 1'b1)
        `CHK(irq, 1'b0)
        wb(1'b1, LVPI_ADR_LV_CTL, 8'h02);
        wb(1'b0, LVPI_ADR_LV_CTL, 8'h07);
        wb(1'b1, LVPI_ADR_LV_CTL, 8'h01);
        wb(1'b0, LVPI_ADR_LV_CTL, 8'h04);
        lowv <= 1'b0;
        repeat (8) @(posedge clk);
        wb(1'b0, LVPI_ADR_LV_CTL, 8'h01);
        `CHK(lv_irq, 1'b0)
        wb(1'b0, LVPI_ADR_IRQ_STAT, 8'h01);
        wb(1'b1, LVPI_ADR_IRQ_EN, 8'h01);
        `CHK(irq, 1'b1)
        wb(1'b1, LVPI_ADR_IRQ_CLR, 8'h01);
        `CHK(irq, 1'b0)
        wb(1'b0, LVPI_ADR_IRQ_STAT, 8'h00);
        r = 8'($urandom_range(7, 0));
        wb(1'b1, LVPI_ADR_RATE, r);
        wb(1'b1, LVPI_ADR_PI_CTL, 8'h80);
        wb(1'b1, LVPI_ADR_PI_CTL, 8'h8E);
        wb(1'b1, LVPI_ADR_PI_CTL, 8'h0E);
        wb(1'b0, LVPI_ADR_PI_CTL, 8'h8E, 8'hFE);
        wpin(1'b1, n);
        wpin(1'b0, n);
        `CHK(n, 1)
        wpin(1'b1, n);
        `CHK(n, r + 1)
        `CHK(pi_irq, 1'b1)
        wb(1'b1, LVPI_ADR_PI_CTL, 8'h9E);
        wpin(1'b0, n);
        wpin(1'b1, n);
        wpin(1'b0, n);
        `CHK(n, r + 2)
        wb(1'b1, LVPI_ADR_PI_CTL, 8'h01);
        repeat (12) @(posedge clk);
        wb(1'b1, LVPI_ADR_PI_CTL, 8'h81);
        wb(1'b0, LVPI_ADR_PI_CTL, 8'h80);
        `CHK(pin, 1'b0)
        `CHK(pi_irq, 1'b0)
        finish_test();
    end
endmodule
